// ### sim/framer_model.sv
// Far-side framer: bipolar receive stream and transmit data
`timescale 1ns/10ps
module framer_model(
	input  wire logic        go_in,
	input  wire logic [31:0] bits_in,
	input  wire logic [31:0] viol_in,
	output logic             lclk_out,
	output logic             pos_out,
	output logic             neg_out,
	output logic             dat_out,
	output logic             done_out
);
	logic last;
	initial begin
		{lclk_out, pos_out, neg_out, dat_out, done_out, last} = 6'h05;
		forever begin
			@(posedge go_in);
			done_out = 1'h0;
			#3;
			for (int i = 0; i < 32; i++) begin
				// A flagged mark repeats the last polarity
				if (bits_in[i])
					last = viol_in[i] ? last : !last;
				lclk_out = 1'h0;
				pos_out = bits_in[i] & last;
				neg_out = bits_in[i] & !last;
				dat_out = bits_in[i];
				#80 lclk_out = 1'h1;
				#80;
			end
			// Clock stops between frames; data lines are left at the complement of the last bit
			lclk_out = 1'h0;
			{pos_out, neg_out, dat_out} = ~{pos_out, neg_out, dat_out};
			done_out = 1'h1;
		end
	end
endmodule

// ### sim/liu_checker.sv
// Port checks for the channel data path
`timescale 1ns/10ps
module liu_checker(
	input wire logic       clk_in,
	input wire logic       nrst_in,
	input wire logic       hsel_in,
	input wire logic [1:0] htrans_in,
	input wire logic       hwrite_in,
	input wire logic       hready_in,
	input wire logic       hreadyout_out,
	input wire logic       host_mode_in,
	input wire logic       single_rail_in,
	input wire logic       rx_output_edge_select_in,
	input wire logic       rx_clk_out,
	input wire logic       rx_pos_or_data_out,
	input wire logic       rx_neg_or_violation_out,
	input wire logic       pulse_active_out,
	input wire logic [6:0] pulse_level_out
);
	wire req = hsel_in && htrans_in[1] && hready_in;
	wire hw  = !host_mode_in;
	wire sel = rx_output_edge_select_in;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	chk_read_wait: assert property (
		req && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out) else $error("read wait");
	chk_write_ready: assert property (
		req && hwrite_in |=> hreadyout_out) else $error("write stall");
	chk_seg_reset: assert property (
		$rose(nrst_in) |-> !pulse_active_out && pulse_level_out == 7'h00) else $error("seg reset");
	chk_pulse_eight: assert property (
		$rose(pulse_active_out) |-> pulse_active_out[*8] ##1 !pulse_active_out)
		else $error("pulse length");
	chk_viol_width: assert property (
		$rose(rx_neg_or_violation_out) && single_rail_in && hw
		|-> rx_neg_or_violation_out[*8] ##[1:12] !rx_neg_or_violation_out)
		else $error("violation width");
	// Edge pin is synchronised, so only judge once it has been steady
	chk_data_rise: assert property (
		hw && !sel && !$past(sel, 8) && $changed(rx_pos_or_data_out) |-> ##[0:1] rx_clk_out)
		else $error("data not on rise");
	chk_data_fall: assert property (
		hw && sel && $past(sel, 8) && $changed(rx_pos_or_data_out) |-> ##[0:1] !rx_clk_out)
		else $error("data not on fall");
	chk_viol_rise: assert property (
		hw && !sel && !$past(sel, 8) && $changed(rx_neg_or_violation_out) |-> ##[0:1] rx_clk_out)
		else $error("violation not on rise");
endmodule
bind liu_channel_digital_datapath liu_checker chk_u (.clk_in, .nrst_in, .hsel_in, .htrans_in,
	.hwrite_in, .hready_in, .hreadyout_out, .host_mode_in, .single_rail_in,
	.rx_output_edge_select_in, .rx_clk_out, .rx_pos_or_data_out, .rx_neg_or_violation_out,
	.pulse_active_out, .pulse_level_out);

// ### sim/tb.sv
// Self-checking bench for the channel data path
`timescale 1ns/10ps
module tb;
	logic        clk_in = 1'h0, nrst_in = 1'h0, mclk_in = 1'h0, hsel_in = 1'h0, go = 1'h0;
	logic        hwrite_in = 1'h0, vprev = 1'h0, jitter_bw_narrow_in = 1'h0;
	logic        rx_output_edge_select_in = 1'h0, tx_neg_or_code_select_in = 1'h1;
	logic        hreadyout_out, rx_neg_or_violation_out, pulse_active_out, pulse_positive_out;
	logic        lclk, pos, neg, dat, done, fifo_deep_in = 1'h0;
	logic [1:0]  htrans_in = 2'h0;
	logic [2:0]  k = 3'h0;
	logic [4:0]  equalizer_config_in = 5'h00;
	logic [6:0]  pulse_level_out;
	logic [7:0]  seg [8] = '{default: 8'h00};
	logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd, bits, viol, vcnt;
	int          n_errors = 0, n_checks = 0, cyc = 0;
	// T1 AMI, E1 valid V, E1 narrow zero run, T1 bare V, T1 valid 000VB0VB
	logic [31:0] cb [5] = '{32'hffffffff, 32'hfffff8ff, 32'hfffff0ff, 32'hfffff0ff, 32'hffffd8ff};
	logic [31:0] cv [5] = '{32'h400, 32'h800, 32'h0, 32'h100000, 32'h4800};
	logic [6:0]  cm [5] = '{7'h40, 7'h18, 7'h38, 7'h00, 7'h00};
	logic [7:0]  bw [5] = '{8'h1e, 8'h64, 8'h0f, 8'h1e, 8'h1e};
	logic [4:0]  nv = 5'h0d;
	liu_channel_digital_datapath dut_u (.clk_in, .nrst_in, .ce_in(1'h1), .hsel_in, .haddr_in,
		.htrans_in, .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out),
		.hrdata_out, .hreadyout_out, .hresp_out(), .host_mode_in(1'h0), .single_rail_in(1'h1),
		.rx_output_edge_select_in, .equalizer_config_in, .jitter_bw_narrow_in,
		.ja_path_select_in(2'h0), .fifo_deep_in, .mclk_in, .rx_clk_in(lclk),
		.rx_pos_in(pos), .rx_neg_in(neg), .tx_clk_in(lclk), .tx_data_in(dat),
		.tx_neg_or_code_select_in, .rx_clk_out(), .rx_pos_or_data_out(),
		.rx_neg_or_violation_out, .tx_clk_out(), .tx_data_out(), .tx_neg_out(),
		.pulse_active_out, .pulse_positive_out, .pulse_level_out);
	framer_model far_u (.go_in(go), .bits_in(bits), .viol_in(viol), .lclk_out(lclk),
		.pos_out(pos), .neg_out(neg), .dat_out(dat), .done_out(done));
	always #5 clk_in = !clk_in;
	always #80 mclk_in = !mclk_in;
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		hsel_in <= 1'h1;
		haddr_in <= {24'h0, a};
		htrans_in <= 2'h2;
		hwrite_in <= wr;
		do @(posedge clk_in); while (hreadyout_out !== 1'h1);
		hsel_in <= 1'h0;
		htrans_in <= 2'h0;
		hwdata_in <= d;
		do @(posedge clk_in); while (hreadyout_out !== 1'h1);
		rd = hrdata_out;
	endtask
	task automatic frame(input logic [31:0] b, input logic [31:0] v);
		bits <= b;
		viol <= v;
		go <= 1'h1;
		@(posedge clk_in);
		go <= 1'h0;
		vcnt = 32'h0;
		do @(posedge clk_in); while (done !== 1'h1);
		// Drain the synchronisers and output stage
		repeat (40) @(posedge clk_in);
	endtask
	always @(posedge clk_in) begin
		cyc++;
		vprev <= rx_neg_or_violation_out;
		if (rx_neg_or_violation_out === 1'h1 && vprev === 1'h0)
			vcnt <= vcnt + 32'h1;
		if (pulse_active_out === 1'h1) begin
			chk({24'h0, pulse_positive_out, pulse_level_out}, {24'h0, seg[k]});
			k <= k + 3'h1;
		end else
			k <= 3'h0;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test;
		end
	end
	initial begin
		repeat (5) @(posedge clk_in);
		nrst_in <= 1'h1;
		for (int j = 0; j < 8; j++) begin
			bus(1'h0, 8'h10 + 8'(4 * j), 32'h0);
			chk(rd, 32'h0);
		end
		for (int i = 0; i < 5; i++) begin
			if (i == 1)
				for (int j = 0; j < 8; j++) begin
					seg[j] = 8'ha3 ^ 8'(37 * j);
					bus(1'h1, 8'h10 + 8'(4 * j), {24'h0, seg[j]});
					bus(1'h0, 8'h10 + 8'(4 * j), 32'h0);
					chk(rd, {24'h0, seg[j]});
				end
			{tx_neg_or_code_select_in, jitter_bw_narrow_in, equalizer_config_in} <= cm[i];
			rx_output_edge_select_in <= i[0];
			fifo_deep_in <= i == 3;
			repeat (8) @(posedge clk_in);
			frame(cb[i], cv[i]);
			chk(vcnt, {31'h0, nv[i]});
			bus(1'h0, 8'h04, 32'h0);
			chk({24'h0, rd[23:16]}, {24'h0, bw[i]});
			chk({31'h0, rd[2]}, {31'h0, i == 2 || i == 3});
		end
		bus(1'h0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		end_of_test;
	end
endmodule

// ### verilog/ja_fifo.sv
// Jitter attenuator FIFO with elastic fill and bandwidth widening
`timescale 1ns/10ps
module ja_fifo
	import liu_pkg::*;
#(
	parameter int WIDTH   = FIFO_W,
	parameter int DEPTH   = FIFO_DEEP,
	parameter int SHALLOW = FIFO_SHALLOW
)
(
	input  wire logic clk_in,
	input  wire logic nrst_in,
	input  wire logic ce_in,
	ja_if.fifo        port
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0]  mem [DEPTH];
	logic [PTR_W-1:0]  wr_ptr;
	logic [PTR_W-1:0]  rd_ptr;
	logic [FILL_W-1:0] count;
	logic [FILL_W-1:0] size;
	ja_state_t         state;
	logic              near_empty;
	logic              near_full;
	logic              do_read;
	logic              do_write;

	always_comb begin
		size = port.deep ? FILL_W'(DEPTH) : FILL_W'(SHALLOW); //RULE8
		near_empty = count <= FILL_W'(NEAR_WIN);
		near_full  = count >= size - FILL_W'(NEAR_WIN);
		// Near full the read follows the writer as well as the master tick; near empty the tick reads nothing
		do_read = (state == JA_RUNNING) && (count != '0) &&
			((port.tick && !near_empty) || (near_full && port.wr_en)); //RULE10 RULE21
		do_write = port.wr_en && ((count < size) || do_read); //RULE21
	end

	always_ff @(posedge clk_in) begin
		if (do_write && ce_in && !port.flush) begin
			mem[wr_ptr] <= port.wr_data;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
			state  <= JA_FILLING;
			port.rd_valid <= 1'b0;
			port.rd_data  <= '0;
			port.wide     <= 1'b0;
		end else if (ce_in) begin
			port.rd_valid <= 1'b0;
			port.wide <= (state == JA_RUNNING) && (near_empty || near_full); //RULE10
			if (port.flush) begin
				wr_ptr <= '0;
				rd_ptr <= '0;
				count  <= '0;
				state  <= JA_FILLING;
			end else begin
				if (do_write) begin
					wr_ptr <= wr_ptr + PTR_W'(1);
				end
				if (do_read) begin
					rd_ptr <= rd_ptr + PTR_W'(1);
					port.rd_data  <= mem[rd_ptr];
					port.rd_valid <= 1'b1;
				end
				count <= count + FILL_W'(do_write) - FILL_W'(do_read);
				case (state)
					JA_FILLING: begin
						// Reading starts half full: 16 or 32 bits of delay
						if (count >= (size >> 1)) begin //RULE9
							state <= JA_RUNNING;
						end
					end
					JA_RUNNING: begin
						if (count == '0) begin
							state <= JA_FILLING;
						end
					end
					default: state <= JA_FILLING;
				endcase
			end
		end
	end

	assign port.fill    = count;
	assign port.running = state == JA_RUNNING;
endmodule

// ### verilog/ja_if.sv
// Link between the channel top and its jitter attenuator FIFO
`timescale 1ns/10ps
interface ja_if;
	import liu_pkg::*;
	logic                wr_en;
	logic [FIFO_W-1:0]   wr_data;
	logic                tick;
	logic                deep;
	logic                flush;
	logic                rd_valid;
	logic [FIFO_W-1:0]   rd_data;
	logic [FILL_W-1:0]   fill;
	logic                wide;
	logic                running;
	modport fifo (input wr_en, wr_data, tick, deep, flush,
		output rd_valid, rd_data, fill, wide, running);
	modport user (output wr_en, wr_data, tick, deep, flush,
		input rd_valid, rd_data, fill, wide, running);
endinterface

// ### verilog/liu_channel_digital_datapath.sv
// Channel digital data path: pin sampling, decoder, jitter attenuator, registers
`timescale 1ns/10ps
module liu_channel_digital_datapath
	import liu_pkg::*;
(
	input  wire logic                       clk_in,
	input  wire logic                       nrst_in,
	input  wire logic                       ce_in,
	input  wire logic                       hsel_in,
	input  wire logic [31:0]                haddr_in,
	input  wire logic [1:0]                 htrans_in,
	input  wire logic                       hwrite_in,
	input  wire logic [2:0]                 hsize_in,
	input  wire logic [31:0]                hwdata_in,
	input  wire logic                       hready_in,
	output logic      [31:0]                hrdata_out,
	output logic                            hreadyout_out,
	output logic                            hresp_out,
	input  wire logic                       host_mode_in,
	input  wire logic                       single_rail_in,
	input  wire logic                       rx_output_edge_select_in,
	input  wire logic [EQC_W-1:0]           equalizer_config_in,
	input  wire logic                       jitter_bw_narrow_in,
	input  wire logic [1:0]                 ja_path_select_in,
	input  wire logic                       fifo_deep_in,
	input  wire logic                       mclk_in,
	input  wire logic                       rx_clk_in,
	input  wire logic                       rx_pos_in,
	input  wire logic                       rx_neg_in,
	input  wire logic                       tx_clk_in,
	input  wire logic                       tx_data_in,
	input  wire logic                       tx_neg_or_code_select_in,
	output logic                            rx_clk_out,
	output logic                            rx_pos_or_data_out,
	output logic                            rx_neg_or_violation_out,
	output logic                            tx_clk_out,
	output logic                            tx_data_out,
	output logic                            tx_neg_out,
	output logic                            pulse_active_out,
	output logic                            pulse_positive_out,
	output logic      [SEG_SIGN-1:0]        pulse_level_out
);
	logic [SYNC_W-1:0]     pins_raw;
	logic [SYNC_W-1:0]     sync1;
	logic [SYNC_W-1:0]     sync2;
	logic [SYNC_W-1:0]     sync3;
	logic [SYNC_W-1:0]     pin;
	logic [SYNC_W-1:0]     pin_d;
	logic [CTL_W-1:0]      ctrl;
	logic [SEG_W-1:0]      seg [SEG_COUNT];
	logic [VIOL_CNT_W-1:0] viol_cnt;
	logic                  host;
	logic                  code_ami;
	logic                  single_rail;
	logic                  edge_sel;
	logic [EQC_W-1:0]      equalizer_config;
	logic                  e1;
	logic                  narrow;
	logic                  deep_eff;
	logic [7:0]            bw_code;
	ja_path_t              ja_path;
	ja_path_t              ja_path_d;
	logic                  ja_rx;
	logic                  ja_tx;
	logic                  rx_rise;
	logic                  tx_rise;
	logic                  mclk_rise;
	logic                  dec_en;
	logic [FIFO_W-1:0]     dec_rails;
	logic                  dec_data;
	logic                  dec_viol;
	logic                  raw_pos;
	logic                  raw_neg;
	logic                  fresh;
	logic                  src_now;
	logic                  src_prev;
	logic                  out_edge;
	logic                  tx_en;
	logic [FIFO_W-1:0]     tx_src;
	logic                  pulse_run;
	logic [SEG_IDX_W-1:0]  seg_idx;
	logic                  dp_write;
	logic                  dp_read;
	logic                  rd_done;
	logic                  dp_hit;
	logic [ADDR_W-1:0]     dp_addr;
	logic                  accept;

	ja_if jbus ();

	function automatic logic rose(input logic now, input logic prev);
		return now & ~prev;
	endfunction

	function automatic logic is_seg(input logic [ADDR_W-1:0] a);
		return (a >= OFF_SEG0) && (a < OFF_SEG0 + ADDR_W'(SEG_COUNT << WORD_SHIFT));
	endfunction

	function automatic logic [SEG_IDX_W-1:0] seg_of(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] rel;
		rel = a - OFF_SEG0;
		return rel[WORD_SHIFT +: SEG_IDX_W];
	endfunction

	// Every outside pin passes three stages; a level counts once stages two and three agree
	assign pins_raw = {equalizer_config_in, ja_path_select_in, host_mode_in, fifo_deep_in,
		jitter_bw_narrow_in, rx_output_edge_select_in, single_rail_in, mclk_in,
		tx_neg_or_code_select_in, tx_data_in, tx_clk_in, rx_neg_in, rx_pos_in, rx_clk_in};

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			pin   <= '0;
			pin_d <= '0;
		end else if (ce_in) begin
			sync1 <= pins_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			pin   <= (sync3 & ~(sync2 ^ sync3)) | (pin & (sync2 ^ sync3));
			pin_d <= pin;
		end
	end

	// Host mode takes the register, hardware mode the shared pins
	always_comb begin
		host        = pin[PIN_HOST];
		code_ami    = host ? ctrl[CTL_CODE] : pin[PIN_TXNEG]; //RULE1 RULE19
		single_rail = host ? ctrl[CTL_SRAIL] : pin[PIN_SRAIL];
		edge_sel    = host ? ctrl[CTL_EDGE] : pin[PIN_EDGE];
		equalizer_config         = host ? ctrl[CTL_EQC +: EQC_W] : pin[PIN_EQC +: EQC_W];
		narrow      = host ? ctrl[CTL_NARROW] : pin[PIN_NARROW]; //RULE13
		ja_path     = ja_path_t'(host ? ctrl[CTL_JA +: 2] : pin[PIN_JA +: 2]); //RULE13
		e1          = equalizer_config[EQC_E1_A] & equalizer_config[EQC_E1_B]; //RULE20
		deep_eff    = (host ? ctrl[CTL_DEEP] : pin[PIN_DEEP]) | (e1 & narrow); //RULE12
		if (!e1) begin
			bw_code = BW_T1_DHZ; //RULE11
		end else if (narrow) begin
			bw_code = BW_E1_NARROW_DHZ; //RULE12
		end else begin
			bw_code = BW_E1_WIDE_DHZ;
		end
		ja_rx = ja_path == JA_RX; //RULE7
		ja_tx = ja_path == JA_TX; //RULE7
		rx_rise   = rose(pin[PIN_RXCLK], pin_d[PIN_RXCLK]);
		tx_rise   = rose(pin[PIN_TXCLK], pin_d[PIN_TXCLK]);
		mclk_rise = rose(pin[PIN_MCLK], pin_d[PIN_MCLK]);
	end

	// One FIFO serves whichever path holds the attenuator
	assign jbus.wr_en   = (ja_rx & rx_rise) | (ja_tx & tx_rise); //RULE21
	assign jbus.wr_data = ja_rx ? {pin[PIN_RXNEG], pin[PIN_RXPOS]}
		: {pin[PIN_TXNEG], pin[PIN_TXDAT]};
	assign jbus.tick    = mclk_rise & (ja_rx | ja_tx); //RULE21
	assign jbus.deep    = deep_eff;
	assign jbus.flush   = !(ja_rx | ja_tx) || (ja_path != ja_path_d);

	ja_fifo u_fifo (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.ce_in   (ce_in),
		.port    (jbus.fifo)
	);

	assign dec_en    = ja_rx ? jbus.rd_valid : rx_rise;
	assign dec_rails = ja_rx ? jbus.rd_data : {pin[PIN_RXNEG], pin[PIN_RXPOS]};

	rx_decoder u_dec (
		.clk_in       (clk_in),
		.nrst_in      (nrst_in),
		.ce_in        (ce_in),
		.bit_en_in    (dec_en),
		.pos_in       (dec_rails[0]),
		.neg_in       (dec_rails[1]),
		.decode_in    (single_rail & ~code_ami), //RULE1
		.ami_check_in (single_rail & code_ami), //RULE5
		.e1_in        (e1),
		.data_out     (dec_data),
		.viol_out     (dec_viol)
	);

	// Output clock is the smoothed master when the attenuator sits on receive
	assign src_now  = ja_rx ? pin[PIN_MCLK] : pin[PIN_RXCLK];
	assign src_prev = ja_rx ? pin_d[PIN_MCLK] : pin_d[PIN_RXCLK];
	assign out_edge = edge_sel ? rose(src_prev, src_now) : rose(src_now, src_prev); //RULE6

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			ja_path_d               <= JA_OFF;
			raw_pos                 <= 1'b0;
			raw_neg                 <= 1'b0;
			fresh                   <= 1'b0;
			rx_clk_out              <= 1'b0;
			rx_pos_or_data_out      <= 1'b0;
			rx_neg_or_violation_out <= 1'b0;
		end else if (ce_in) begin
			ja_path_d  <= ja_path;
			rx_clk_out <= src_now;
			if (dec_en) begin
				raw_pos <= dec_rails[0];
				raw_neg <= dec_rails[1];
			end
			// A new bit wins over consumption in the same cycle
			if (dec_en) begin
				fresh <= 1'b1;
			end else if (out_edge) begin
				fresh <= 1'b0;
			end
			if (out_edge) begin
				rx_pos_or_data_out <= single_rail ? dec_data : raw_pos;
				// Stale bits read as no violation so a pulse lasts one clock
				rx_neg_or_violation_out <= single_rail ? (dec_viol & fresh) : raw_neg; //RULE3
			end
		end
	end

	// Transmit: pass through, or smooth a gapped clock through the FIFO
	assign tx_en  = ja_tx ? jbus.rd_valid : tx_rise; //RULE14
	assign tx_src = ja_tx ? jbus.rd_data : {pin[PIN_TXNEG], pin[PIN_TXDAT]};

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			tx_clk_out  <= 1'b0;
			tx_data_out <= 1'b0;
			tx_neg_out  <= 1'b0;
		end else if (ce_in) begin
			tx_clk_out <= ja_tx ? pin[PIN_MCLK] : pin[PIN_TXCLK]; //RULE14
			if (tx_en) begin
				tx_data_out <= tx_src[0];
				// In single rail the negative pin carries code select, not data
				tx_neg_out  <= single_rail ? 1'b0 : tx_src[1];
			end
		end
	end

	// Each mark plays the eight segment words, one per clock
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			pulse_run          <= 1'b0;
			seg_idx            <= '0;
			pulse_active_out   <= 1'b0;
			pulse_positive_out <= 1'b0;
			pulse_level_out    <= '0;
		end else if (ce_in) begin
			if (tx_en && (tx_src[0] | (tx_src[1] & ~single_rail))) begin
				pulse_run <= 1'b1;
				seg_idx   <= '0;
			end else if (pulse_run) begin
				seg_idx   <= seg_idx + SEG_IDX_W'(1);
				pulse_run <= seg_idx != SEG_IDX_W'(SEG_COUNT - 1); //RULE16
			end
			pulse_active_out   <= pulse_run;
			pulse_positive_out <= pulse_run & seg[seg_idx][SEG_SIGN]; //RULE17
			pulse_level_out    <= pulse_run ? seg[seg_idx][SEG_SIGN-1:0] : '0; //RULE16
		end
	end

	// AHB-Lite slave: writes take no wait, reads take one
	assign accept        = hsel_in & htrans_in[1] & hready_in;
	assign hreadyout_out = !(dp_read && !rd_done);
	assign hresp_out     = 1'b0;

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			dp_write   <= 1'b0;
			dp_read    <= 1'b0;
			rd_done    <= 1'b0;
			dp_hit     <= 1'b0;
			dp_addr    <= '0;
			hrdata_out <= '0;
		end else if (ce_in) begin
			if (hready_in) begin
				dp_write <= accept & hwrite_in;
				dp_read  <= accept & ~hwrite_in;
				dp_hit   <= haddr_in[31:ADDR_W] == '0;
				dp_addr  <= haddr_in[ADDR_W-1:0];
				rd_done  <= 1'b0;
			end else if (dp_read) begin
				rd_done    <= 1'b1;
				hrdata_out <= '0;
				if (!dp_hit) begin
					hrdata_out <= '0;
				end else if (dp_addr == OFF_CTRL) begin
					hrdata_out <= {{(32-CTL_W){1'b0}}, ctrl};
				end else if (dp_addr == OFF_STAT) begin
					hrdata_out[STAT_E1]   <= e1;
					hrdata_out[STAT_WIDE] <= jbus.wide;
					hrdata_out[STAT_DEEP] <= deep_eff;
					hrdata_out[STAT_RUN]  <= jbus.running;
					hrdata_out[STAT_FILL +: FILL_W] <= jbus.fill;
					hrdata_out[STAT_BW +: 8] <= bw_code;
				end else if (dp_addr == OFF_VIOL) begin
					hrdata_out <= {{(32-VIOL_CNT_W){1'b0}}, viol_cnt};
				end else if (is_seg(dp_addr)) begin
					hrdata_out <= {{(32-SEG_W){1'b0}}, seg[seg_of(dp_addr)]};
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			ctrl <= CTL_RESET;
			for (int i = 0; i < SEG_COUNT; i++) begin
				seg[i] <= SEG_RESET; //RULE18
			end
		end else if (ce_in && dp_write && hready_in && dp_hit) begin
			if (dp_addr == OFF_CTRL) begin
				ctrl <= hwdata_in[CTL_W-1:0];
			end else if (is_seg(dp_addr)) begin
				seg[seg_of(dp_addr)] <= hwdata_in[SEG_W-1:0];
			end
		end
	end

	// Violation count: a new violation wins over a software clear
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			viol_cnt <= '0;
		end else if (ce_in) begin
			if (out_edge && single_rail && dec_viol && fresh) begin
				viol_cnt <= viol_cnt + VIOL_CNT_W'(1);
			end else if (dp_write && hready_in && dp_hit && dp_addr == OFF_VIOL) begin
				viol_cnt <= '0;
			end
		end
	end
endmodule

// ### verilog/liu_pkg.sv
// Constants and types shared by the line interface channel data path
// Summary of operation
// RULE1: Decoder enabled per channel, single rail only
// RULE2: Decode HDB3 for E1, B8ZS for T1
// RULE3: Nonconforming violation gives one-clock violation pulse
// RULE4: E1 only: excessive zeros also flagged
// RULE5: AMI single rail flags every bipolar violation
// RULE6: Edge select 1 falling, 0 rising output update
// RULE7: Jitter attenuator in receive, transmit, or bypassed
// RULE8: FIFO depth selectable 2x32 or 2x64
// RULE9: Latency 16 or 32 bit periods
// RULE10: Near pointer limits widen bandwidth until clear
// RULE11: T1 bandwidth fixed at 3 Hz
// RULE12: E1 narrow: 10 to 1.5 Hz, forces 64
// RULE13: Host mode per channel, hardware mode global
// RULE14: Transmit path smooths gaps up to 20/50 UI
// RULE15: Loop timing systems use receive path placement
// RULE16: Pulse built from eight 7-bit segment words
// RULE17: Segment bit 7 is sign, 1 positive
// RULE18: Segment words reset to zero
// RULE19: Code select high AMI, low HDB3/B8ZS
// RULE20: E1 when top two equalizer bits set
// RULE21: FIFO written by path clock, read by master; near full the code also reads on every path clock write
package liu_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_VIOL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_SEG0 = 8'h10;
	localparam int WORD_SHIFT = 2;

	localparam int SEG_COUNT = 8;
	localparam int SEG_W     = 8;
	localparam int SEG_SIGN  = 7;
	localparam int SEG_IDX_W = 3;
	localparam logic [SEG_W-1:0] SEG_RESET = 8'h00;

	localparam int CTL_W      = 16;
	localparam logic [CTL_W-1:0] CTL_RESET = 16'h0000;
	localparam int CTL_CODE   = 0;
	localparam int CTL_SRAIL  = 1;
	localparam int CTL_EDGE   = 2;
	localparam int CTL_NARROW = 3;
	localparam int CTL_DEEP   = 4;
	localparam int CTL_JA     = 5;
	localparam int CTL_EQC    = 8;

	localparam int EQC_W    = 5;
	localparam int EQC_E1_A = 4;
	localparam int EQC_E1_B = 3;

	localparam int STAT_E1   = 0;
	localparam int STAT_WIDE = 1;
	localparam int STAT_DEEP = 2;
	localparam int STAT_RUN  = 3;
	localparam int STAT_FILL = 8;
	localparam int STAT_BW   = 16;

	typedef enum logic [1:0] {
		JA_OFF  = 2'b00,
		JA_RX   = 2'b01,
		JA_TX   = 2'b10,
		JA_NONE = 2'b11
	} ja_path_t;

	typedef enum logic {
		JA_FILLING = 1'b0,
		JA_RUNNING = 1'b1
	} ja_state_t;

	localparam int FIFO_W       = 2;
	localparam int FIFO_SHALLOW = 32;
	localparam int FIFO_DEEP    = 64;
	localparam int FILL_W       = 7;
	localparam int NEAR_WIN     = 2;
	localparam int GAP_SHALLOW_UI = 20;
	localparam int GAP_DEEP_UI    = 50;

	// Loop bandwidth in tenths of a hertz
	localparam logic [7:0] BW_T1_DHZ        = 8'h1e;
	localparam logic [7:0] BW_E1_WIDE_DHZ   = 8'h64;
	localparam logic [7:0] BW_E1_NARROW_DHZ = 8'h0f;

	localparam int DEC_WIN  = 8;
	localparam int ZRUN_W   = 3;
	localparam logic [ZRUN_W-1:0] HDB3_ZERO_RUN = 3'h4;
	localparam int VIOL_CNT_W = 16;

	localparam int PIN_RXCLK  = 0;
	localparam int PIN_RXPOS  = 1;
	localparam int PIN_RXNEG  = 2;
	localparam int PIN_TXCLK  = 3;
	localparam int PIN_TXDAT  = 4;
	localparam int PIN_TXNEG  = 5;
	localparam int PIN_MCLK   = 6;
	localparam int PIN_SRAIL  = 7;
	localparam int PIN_EDGE   = 8;
	localparam int PIN_NARROW = 9;
	localparam int PIN_DEEP   = 10;
	localparam int PIN_HOST   = 11;
	localparam int PIN_JA     = 12;
	localparam int PIN_EQC    = 14;
	localparam int SYNC_W     = 19;
endpackage

// ### verilog/rx_decoder.sv
// Receive line code decoder with violation detection
`timescale 1ns/10ps
module rx_decoder
	import liu_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic nrst_in,
	input  wire logic ce_in,
	input  wire logic bit_en_in,
	input  wire logic pos_in,
	input  wire logic neg_in,
	input  wire logic decode_in,
	input  wire logic ami_check_in,
	input  wire logic e1_in,
	output logic      data_out,
	output logic      viol_out
);
	// Index 0 holds the newest bit; the oldest leaves the window
	logic [DEC_WIN-1:0] mark;
	logic [DEC_WIN-1:0] pol;
	logic [DEC_WIN-1:0] err;
	logic               last_pol;
	logic               seen;
	logic [ZRUN_W-1:0]  zrun;
	logic               is_mark;
	logic               bpv;
	logic               hdb3_ok;
	logic               b8zs_ok;
	logic               new_mark;
	logic               new_err;
	logic [DEC_WIN-1:0] keep;

	always_comb begin
		is_mark = pos_in | neg_in;
		bpv = is_mark && seen && (pos_in == last_pol);
		hdb3_ok = bpv && (mark[1:0] == 2'b00);
		b8zs_ok = is_mark && mark[0] && !mark[1] && mark[2] && mark[3] &&
			(mark[6:4] == 3'b000) && (pol[3] != pol[2]) &&
			(pol[0] == pol[2]) && (pos_in != pol[0]);
		keep = '1;
		new_mark = is_mark;
		new_err = 1'b0;
		if (decode_in) begin
			if (e1_in) begin
				if (hdb3_ok) begin //RULE2
					new_mark = 1'b0;
					keep[2] = 1'b0;
				end else begin
					new_err = bpv; //RULE3
				end
				if (!is_mark && (zrun == HDB3_ZERO_RUN - 3'h1)) begin
					new_err = 1'b1; //RULE4
				end
			end else begin
				if (b8zs_ok) begin //RULE2
					new_mark = 1'b0;
					keep[0] = 1'b0;
					keep[2] = 1'b0;
					keep[3] = 1'b0;
				end
				new_err = bpv;
			end
		end else if (ami_check_in) begin
			new_err = bpv; //RULE5
		end
	end

	// B8ZS violations are flagged on entry and withdrawn once the pattern completes
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			mark     <= '0;
			pol      <= '0;
			err      <= '0;
			last_pol <= 1'b0;
			seen     <= 1'b0;
			zrun     <= '0;
			data_out <= 1'b0;
			viol_out <= 1'b0;
		end else if (ce_in && bit_en_in) begin
			data_out <= decode_in ? mark[DEC_WIN-1] : is_mark;
			viol_out <= decode_in ? err[DEC_WIN-1] : new_err;
			mark <= {mark[DEC_WIN-2:0] & keep[DEC_WIN-2:0], new_mark};
			err  <= {err[DEC_WIN-2:0] & keep[DEC_WIN-2:0], new_err & keep[0]};
			pol  <= {pol[DEC_WIN-2:0], pos_in};
			if (is_mark) begin
				last_pol <= pos_in;
				seen     <= 1'b1;
				zrun     <= '0;
			end else if (zrun != HDB3_ZERO_RUN) begin
				zrun <= zrun + 3'h1;
			end
		end
	end
endmodule
